// file: rtl/dss_pkg.sv
// Package for the DMA service channel select bank: offsets, reset values, field layouts.
// Assumes a 32-bit APB register bus and nine DMA channel engines on the same clock.
package dss_pkg;

	// ==========================================================================
	// Sizes
	// ==========================================================================
	localparam int DSS_NUM_CHAN = 9;
	localparam int DSS_NUM_SRC = 7;
	localparam int DSS_SEL_W = 4;
	localparam int DSS_ADDR_W = 12;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [DSS_ADDR_W-1:0] DSS_OFS_SEL_ZERO = 12'h004;
	localparam logic [DSS_ADDR_W-1:0] DSS_OFS_SEL_ONE = 12'h008;
	localparam logic [31:0] DSS_RST_SEL_ZERO = 32'h0fffffff;
	localparam logic [31:0] DSS_RST_SEL_ONE = 32'h0fffffff;

	// Highest code that names a channel; codes above it are reserved.
	localparam logic [DSS_SEL_W-1:0] DSS_MAX_CODE = 4'h8;

	// Request source indices.
	localparam int DSS_SRC_SP0_RX = 0;
	localparam int DSS_SRC_SP0_TX = 1;
	localparam int DSS_SRC_CONV_RX = 2;
	localparam int DSS_SRC_AP1_TX = 3;
	localparam int DSS_SRC_AP1_RX = 4;
	localparam int DSS_SRC_AP0_TX = 5;
	localparam int DSS_SRC_AP0_RX = 6;

	// ==========================================================================
	// Field layouts
	// ==========================================================================
	typedef struct packed {
		logic [23:0] other_ports;
		logic [3:0] serial_port0_tx_chan_sel;
		logic [3:0] serial_port0_rx_chan_sel;
	} dss_sel_zero_s;

	typedef struct packed {
		logic [3:0] rsvd_hi;
		logic [3:0] converter_rx_chan_sel;
		logic [7:0] rsvd_mid;
		logic [3:0] async_port1_tx_chan_sel;
		logic [3:0] async_port1_rx_chan_sel;
		logic [3:0] async_port0_tx_chan_sel;
		logic [3:0] async_port0_rx_chan_sel;
	} dss_sel_one_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dss_apb_rsp_s;

endpackage

// file: rtl/dss_channel_select.sv
// Service channel select bank: two APB registers whose 4-bit fields route seven peripheral
// request lines to nine DMA channels, and route each channel's acknowledge back.
// Assumes requests and acknowledges come from logic on pclk, so they are not synchronised.
//
// Functional notes
// (RULE1) Codes 0..8 pick channels 0..8; other codes pick no channel.
// (RULE2) Register zero bits 3:0 route serial port 0 receive requests.
// (RULE3) Register zero bits 7:4 route serial port 0 transmit requests.
// (RULE4) Register one bits 27:24 route converter receive requests.
// (RULE5) Register one bits 15:12 route async port 1 transmit requests.
// (RULE6) Register one bits 11:8 route async port 1 receive requests.
// (RULE7) Register one bits 7:4 route async port 0 transmit requests.
// (RULE8) All register one fields share the common channel code.
// (RULE9) Register one sits at 0x08, read/write, resets to 0x0fffffff.
// (RULE10) Register one bits 3:0 route async port 0 receive requests.
// (RULE11) Reserved codes route nowhere; a channel forwards only its selecting peripheral.
`timescale 1ns/1ps

module dss_channel_select
	import dss_pkg::*;
(
	input wire logic pclk, // APB and routing clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic pce, // Clock enable; all state holds while low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write when high
	input wire logic [DSS_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [DSS_NUM_SRC-1:0] periph_req, // Peripheral request lines
	output logic [DSS_NUM_SRC-1:0] periph_ack, // Acknowledge to each peripheral
	input wire logic [DSS_NUM_CHAN-1:0] chan_ack, // Acknowledge from each channel
	output logic [DSS_NUM_CHAN-1:0] chan_req // Request to each channel
);

	// ==========================================================================
	// Functions
	// ==========================================================================
	// Turns a channel code into a one-hot channel vector, empty for reserved codes.
	function automatic logic [DSS_NUM_CHAN-1:0] dss_decode(input logic [DSS_SEL_W-1:0] code);
		logic [DSS_NUM_CHAN-1:0] hot;
		hot = '0;
		if (code <= DSS_MAX_CODE) begin // [RULE1]
			hot[code] = 1'h1;
		end
		return hot;
	endfunction

	// Keeps only the lowest set bit, so the lowest source index owns a shared channel.
	function automatic logic [DSS_NUM_SRC-1:0] dss_first(input logic [DSS_NUM_SRC-1:0] want);
		logic [DSS_NUM_SRC-1:0] pick;
		logic taken;
		pick = '0;
		taken = 1'h0;
		for (int s = 0; s < DSS_NUM_SRC; s++) begin
			if (want[s] && !taken) begin
				pick[s] = 1'h1;
				taken = 1'h1;
			end
		end
		return pick;
	endfunction

	// Compares the bus address with one register offset.
	function automatic logic dss_hit(input logic [DSS_ADDR_W-1:0] addr, input logic [DSS_ADDR_W-1:0] ofs);
		return addr == ofs;
	endfunction

	// ==========================================================================
	// Registers
	// ==========================================================================
	dss_sel_zero_s sel_zero;
	dss_sel_one_s sel_one;
	dss_sel_zero_s wd_zero;
	dss_sel_one_s wd_one;
	dss_apb_rsp_s rsp_q;
	logic [DSS_NUM_CHAN-1:0] chan_req_q;
	logic [DSS_NUM_SRC-1:0] periph_ack_q;

	logic [DSS_SEL_W-1:0] serial_port0_rx_chan_sel_q;
	logic [DSS_SEL_W-1:0] serial_port0_tx_chan_sel_q;
	logic [23:0] zero_store_q;
	logic [DSS_SEL_W-1:0] converter_rx_chan_sel_q;
	logic [DSS_SEL_W-1:0] async_port1_tx_chan_sel_q;
	logic [DSS_SEL_W-1:0] async_port1_rx_chan_sel_q;
	logic [DSS_SEL_W-1:0] async_port0_tx_chan_sel_q;
	logic [DSS_SEL_W-1:0] async_port0_rx_chan_sel_q;
	logic [3:0] one_hi_q;
	logic [7:0] one_mid_q;

	// Reset images of both registers, viewed field by field.
	localparam dss_sel_zero_s RST_ZERO = DSS_RST_SEL_ZERO;
	localparam dss_sel_one_s RST_ONE = DSS_RST_SEL_ONE;

	// ==========================================================================
	// Bus decode
	// ==========================================================================
	// One-hot bus state: idle, or answering the access phase of one transfer.
	typedef enum logic [1:0] {
		DSS_BUS_IDLE = 2'h1,
		DSS_BUS_ANSWER = 2'h2
	} dss_bus_e;

	dss_bus_e bus_q;
	dss_bus_e bus_d;
	logic setup_phase;
	logic access_done;
	logic hit_zero;
	logic hit_one;
	logic wr_zero;
	logic wr_one;

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & (bus_q == DSS_BUS_ANSWER);
	assign hit_zero = dss_hit(paddr, DSS_OFS_SEL_ZERO);
	assign hit_one = dss_hit(paddr, DSS_OFS_SEL_ONE);
	assign wr_zero = access_done & pwrite & hit_zero;
	assign wr_one = access_done & pwrite & hit_one;
	assign wd_zero = pwdata;
	assign wd_one = pwdata;

	// A new setup may follow the access phase at once, so both states look at it.
	always_comb begin
		unique case (bus_q)
			DSS_BUS_IDLE: begin
				bus_d = setup_phase ? DSS_BUS_ANSWER : DSS_BUS_IDLE;
			end
			DSS_BUS_ANSWER: begin
				bus_d = setup_phase ? DSS_BUS_ANSWER : DSS_BUS_IDLE;
			end
			default: begin
				bus_d = DSS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q <= DSS_BUS_IDLE;
		end else if (pce) begin
			bus_q <= bus_d;
		end
	end

	// ==========================================================================
	// APB response
	// ==========================================================================
	// The answer is prepared in the setup cycle so the access phase completes at once
	// while all bus outputs still come from flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_q <= '0;
		end else if (pce) begin
			rsp_q.pready <= setup_phase;
			rsp_q.pslverr <= setup_phase & ~(hit_zero | hit_one);
			if (setup_phase && !pwrite && hit_zero) begin
				rsp_q.prdata <= sel_zero;
			end else if (setup_phase && !pwrite && hit_one) begin
				rsp_q.prdata <= sel_one; // [RULE9]
			end else begin
				rsp_q.prdata <= '0;
			end
		end
	end

	// ==========================================================================
	// Register zero fields
	// ==========================================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_port0_rx_chan_sel_q <= RST_ZERO.serial_port0_rx_chan_sel;
		end else if (pce && wr_zero) begin
			serial_port0_rx_chan_sel_q <= wd_zero.serial_port0_rx_chan_sel; // [RULE2]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_port0_tx_chan_sel_q <= RST_ZERO.serial_port0_tx_chan_sel;
		end else if (pce && wr_zero) begin
			serial_port0_tx_chan_sel_q <= wd_zero.serial_port0_tx_chan_sel; // [RULE3]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_store_q <= RST_ZERO.other_ports;
		end else if (pce && wr_zero) begin
			zero_store_q <= wd_zero.other_ports;
		end
	end

	// ==========================================================================
	// Register one fields
	// ==========================================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_rx_chan_sel_q <= RST_ONE.converter_rx_chan_sel; // [RULE9]
		end else if (pce && wr_one) begin
			converter_rx_chan_sel_q <= wd_one.converter_rx_chan_sel; // [RULE4]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_port1_tx_chan_sel_q <= RST_ONE.async_port1_tx_chan_sel; // [RULE9]
		end else if (pce && wr_one) begin
			async_port1_tx_chan_sel_q <= wd_one.async_port1_tx_chan_sel; // [RULE5]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_port1_rx_chan_sel_q <= RST_ONE.async_port1_rx_chan_sel; // [RULE9]
		end else if (pce && wr_one) begin
			async_port1_rx_chan_sel_q <= wd_one.async_port1_rx_chan_sel; // [RULE6]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_port0_tx_chan_sel_q <= RST_ONE.async_port0_tx_chan_sel; // [RULE9]
		end else if (pce && wr_one) begin
			async_port0_tx_chan_sel_q <= wd_one.async_port0_tx_chan_sel; // [RULE7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_port0_rx_chan_sel_q <= RST_ONE.async_port0_rx_chan_sel; // [RULE9]
		end else if (pce && wr_one) begin
			async_port0_rx_chan_sel_q <= wd_one.async_port0_rx_chan_sel; // [RULE10]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			one_hi_q <= RST_ONE.rsvd_hi; // [RULE9]
		end else if (pce && wr_one) begin
			one_hi_q <= wd_one.rsvd_hi;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			one_mid_q <= RST_ONE.rsvd_mid; // [RULE9]
		end else if (pce && wr_one) begin
			one_mid_q <= wd_one.rsvd_mid;
		end
	end

	// ==========================================================================
	// Register views
	// ==========================================================================
	always_comb begin
		sel_zero.other_ports = zero_store_q;
		sel_zero.serial_port0_tx_chan_sel = serial_port0_tx_chan_sel_q;
		sel_zero.serial_port0_rx_chan_sel = serial_port0_rx_chan_sel_q;
	end

	always_comb begin
		sel_one.rsvd_hi = one_hi_q;
		sel_one.converter_rx_chan_sel = converter_rx_chan_sel_q;
		sel_one.rsvd_mid = one_mid_q;
		sel_one.async_port1_tx_chan_sel = async_port1_tx_chan_sel_q;
		sel_one.async_port1_rx_chan_sel = async_port1_rx_chan_sel_q;
		sel_one.async_port0_tx_chan_sel = async_port0_tx_chan_sel_q;
		sel_one.async_port0_rx_chan_sel = async_port0_rx_chan_sel_q;
	end

	// ==========================================================================
	// Routing
	// ==========================================================================
	logic [DSS_NUM_CHAN-1:0] src_hot [DSS_NUM_SRC];
	logic [DSS_NUM_SRC-1:0] want [DSS_NUM_CHAN];
	logic [DSS_NUM_SRC-1:0] owner [DSS_NUM_CHAN];
	logic [DSS_NUM_CHAN-1:0] route_req;
	logic [DSS_NUM_SRC-1:0] route_ack;

	always_comb begin
		src_hot[DSS_SRC_SP0_RX] = dss_decode(serial_port0_rx_chan_sel_q); // [RULE2]
		src_hot[DSS_SRC_SP0_TX] = dss_decode(serial_port0_tx_chan_sel_q); // [RULE3]
		src_hot[DSS_SRC_CONV_RX] = dss_decode(converter_rx_chan_sel_q); // [RULE4] [RULE8]
		src_hot[DSS_SRC_AP1_TX] = dss_decode(async_port1_tx_chan_sel_q); // [RULE5] [RULE8]
		src_hot[DSS_SRC_AP1_RX] = dss_decode(async_port1_rx_chan_sel_q); // [RULE6] [RULE8]
		src_hot[DSS_SRC_AP0_TX] = dss_decode(async_port0_tx_chan_sel_q); // [RULE7] [RULE8]
		src_hot[DSS_SRC_AP0_RX] = dss_decode(async_port0_rx_chan_sel_q); // [RULE10] [RULE8]
	end

	// Each channel lists the peripherals whose field names it.
	always_comb begin
		for (int c = 0; c < DSS_NUM_CHAN; c++) begin
			for (int s = 0; s < DSS_NUM_SRC; s++) begin
				want[c][s] = src_hot[s][c];
			end
		end
	end

	// When two peripherals name the same channel, the lower source index owns it, so a
	// channel never sees a mixture of two peripherals' requests.
	always_comb begin
		for (int c = 0; c < DSS_NUM_CHAN; c++) begin
			owner[c] = dss_first(want[c]); // [RULE11]
		end
	end

	always_comb begin
		route_req = '0;
		for (int c = 0; c < DSS_NUM_CHAN; c++) begin
			route_req[c] = |(owner[c] & periph_req); // [RULE11]
		end
	end

	always_comb begin
		route_ack = '0;
		for (int c = 0; c < DSS_NUM_CHAN; c++) begin
			route_ack = route_ack | (owner[c] & {DSS_NUM_SRC{chan_ack[c]}}); // [RULE11]
		end
	end

	// ==========================================================================
	// Output flops
	// ==========================================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_req_q <= '0;
		end else if (pce) begin
			chan_req_q <= route_req; // [RULE11]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_ack_q <= '0;
		end else if (pce) begin
			periph_ack_q <= route_ack; // [RULE11]
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign prdata = rsp_q.prdata;
	assign pready = rsp_q.pready;
	assign pslverr = rsp_q.pslverr;
	assign chan_req = chan_req_q;
	assign periph_ack = periph_ack_q;

endmodule

// file: testbench/dss_far_model.sv
// Channel engines on the far side of the select bank.
// Assumes the same pclk; slow makes each acknowledge come one cycle later.
`timescale 1ns/1ps
module dss_far_model
	import dss_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic slow, // answer late
	input wire logic [DSS_NUM_CHAN-1:0] chan_req, // channel requests
	output logic [DSS_NUM_CHAN-1:0] chan_ack // channel acknowledges
);
	logic [DSS_NUM_CHAN-1:0] seen_q;
	always_ff @(posedge pclk) begin
		seen_q <= chan_req;
		chan_ack <= slow ? (seen_q & chan_req) : chan_req;
	end
endmodule

// file: testbench/dss_channel_select_assertions.sv
// Checker for the select bank; shadows both registers from completed writes.
// Assumes pce falls only while the bus is idle.
`timescale 1ns/1ps
module dss_channel_select_assertions
	import dss_pkg::*;
(
	input wire logic pclk, presetn, pce, psel, penable, pwrite,
	input wire logic [DSS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic pready, pslverr,
	input wire logic [DSS_NUM_SRC-1:0] periph_req, periph_ack,
	input wire logic [DSS_NUM_CHAN-1:0] chan_ack, chan_req
);
	logic [31:0] r0_q, r1_q;
	logic [27:0] codes;
	logic [3:0] code_d, code_q;
	logic [6:0] req_q;
	logic [8:0] ack_q;
	logic stp;
	assign stp = pce && psel && !penable;
	assign codes = {r1_q[3:0], r1_q[7:4], r1_q[11:8], r1_q[15:12], r1_q[27:24], r0_q[7:4], r0_q[3:0]};
	always_comb begin
		code_d = 4'hf;
		for (int i = 0; i < 7; i++)
			if (periph_req[i]) code_d = codes[4*i+:4];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r0_q <= 32'h0fffffff;
			r1_q <= 32'h0fffffff;
			req_q <= 7'h0;
			code_q <= 4'hf;
			ack_q <= 9'h0;
		end else if (pce) begin
			if (psel && penable && pready && pwrite && paddr == DSS_OFS_SEL_ZERO) r0_q <= pwdata;
			if (psel && penable && pready && pwrite && paddr == DSS_OFS_SEL_ONE) r1_q <= pwdata;
			req_q <= periph_req;
			code_q <= code_d;
			ack_q <= chan_ack;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; stp |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_idle; !psel |=> !pready; endproperty
	a_idle: assert property (p_idle) else $error("ready without setup");
	property p_err; stp && paddr != DSS_OFS_SEL_ZERO && paddr != DSS_OFS_SEL_ONE |=> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_rd1; stp && !pwrite && paddr == DSS_OFS_SEL_ONE |=> prdata == r1_q && !pslverr; endproperty
	a_rd1: assert property (p_rd1) else $error("register one read wrong");
	property p_rd0; stp && !pwrite && paddr == DSS_OFS_SEL_ZERO |=> prdata == r0_q && !pslverr; endproperty
	a_rd0: assert property (p_rd0) else $error("register zero read wrong");
	property p_route; $onehot(req_q) && code_q <= DSS_MAX_CODE |-> chan_req == (9'h1 << code_q); endproperty
	a_route: assert property (p_route) else $error("request on wrong channel");
	property p_rsv; $onehot(req_q) && code_q > DSS_MAX_CODE |-> chan_req == 9'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code routed");
	property p_ack; $onehot(req_q) && code_q <= DSS_MAX_CODE |-> (|(periph_ack & req_q)) == ack_q[code_q]; endproperty
	a_ack: assert property (p_ack) else $error("acknowledge not relayed");
endmodule
bind dss_channel_select dss_channel_select_assertions i_chk (.pclk(pclk), .presetn(presetn), .pce(pce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .periph_req(periph_req), .periph_ack(periph_ack),
	.chan_ack(chan_ack), .chan_req(chan_req));

// file: testbench/dss_channel_select_tb_top.sv
// Testbench for the select bank: APB master tasks and routing checks.
// Assumes the channel engine model on the far side.
`timescale 1ns/1ps
module dss_channel_select_tb_top;
	import dss_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, pce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
	logic [DSS_ADDR_W-1:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic [DSS_NUM_SRC-1:0] periph_req = 7'h0, periph_ack;
	logic [DSS_NUM_CHAN-1:0] chan_ack, chan_req;
	logic [3:0] map [7] = '{4'h7, 4'h8, 4'h5, 4'h2, 4'h3, 4'h1, 4'h4};
	int fails = 0, total_checks = 0;
	always #10 pclk = ~pclk;
	dss_channel_select i_dss_channel_select (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_req(periph_req), .periph_ack(periph_ack), .chan_ack(chan_ack), .chan_req(chan_req));
	dss_far_model i_dss_far_model (.pclk(pclk), .slow(slow), .chan_req(chan_req), .chan_ack(chan_ack));
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic route(input int s, input logic [8:0] e);
		periph_req <= 7'h1 << s;
		repeat (5) @(posedge pclk);
		chk("chan_req", {23'h0, e}, {23'h0, chan_req});
		chk("periph_ack", {25'h0, (e != 9'h0) ? 7'h1 << s : 7'h0}, {25'h0, periph_ack});
		periph_req <= 7'h0;
		repeat (5) @(posedge pclk);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		rdc("sel_one", DSS_OFS_SEL_ONE, 32'h0fffffff);
		rdc("sel_zero", DSS_OFS_SEL_ZERO, 32'h0fffffff);
		route(6, 9'h0);
		for (int c = 0; c < 16; c++) begin
			slow <= c[0];
			xfer(1'h1, DSS_OFS_SEL_ONE, 32'h0ffffff0 | c);
			route(6, (c < 9) ? 9'h1 << c : 9'h0);
		end
		xfer(1'h1, DSS_OFS_SEL_ONE, 32'ha5f02314);
		xfer(1'h1, DSS_OFS_SEL_ZERO, 32'h12345687);
		rdc("sel_one", DSS_OFS_SEL_ONE, 32'ha5f02314);
		for (int s = 0; s < 7; s++)
			route(s, 9'h1 << map[s]);
		pce <= 1'h0;
		periph_req <= 7'h40;
		repeat (5) @(posedge pclk);
		chk("frozen chan_req", 32'h0, {23'h0, chan_req});
		pce <= 1'h1;
		repeat (5) @(posedge pclk);
		chk("chan_req", 32'h1 << map[6], {23'h0, chan_req});
		periph_req <= 7'h0;
		repeat (5) @(posedge pclk);
		xfer(1'h1, 12'h00c, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		rdc("sel_zero", DSS_OFS_SEL_ZERO, 32'h12345687);
		test_done;
	end
	initial begin
		repeat (2000) @(posedge pclk);
		fails++;
		test_done;
	end
endmodule
